// *** include/aocc_pkg.sv ***
// package: register map, field layout, defaults and timing counts for the converter output control
package aocc_pkg;

    localparam logic [6:0] ADDR_TIMING = 7'h03;
    localparam logic [6:0] ADDR_IMP_A = 7'h04;
    localparam logic [6:0] ADDR_IMP_B = 7'h05;
    localparam logic [6:0] ADDR_DIVFMT = 7'h06;
    localparam logic [6:0] ADDR_RSVD = 7'h07;
    localparam logic [6:0] ADDR_BIAS = 7'h08;
    localparam logic [6:0] ADDR_SRST = 7'h0A;

    localparam logic [7:0] RST_TIMING = 8'h6D;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] SRST_KEY = 8'h5A;
    localparam logic [7:0] SRST_STATUS = 8'h14;

    localparam int BIT_SKIP = 7;
    localparam int BIT_HALF = 6;
    localparam int BIT_PAT_SEL = 7;
    localparam int BIT_PAT_EN = 6;
    localparam int BIT_ALIGN_EDGE = 2;

    localparam logic [1:0] FMT_OFFSET = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;

    localparam logic [7:0] PAT_ODD = 8'h55;
    localparam logic [7:0] PAT_EVEN = 8'hAA;

    localparam int LATENCY = 9;
    localparam int SYNC_EDGE = 3;
    localparam logic [3:0] TRIM_STEPS = 4'h3;
    localparam logic [3:0] STROBE_LEAD = 4'h2;
    localparam real SKIP_SAVE_NS = 3.4;
    localparam real CLK_NS = 5.0;
    localparam int SERIAL_BITS = 16;

    typedef struct packed {
        logic [7:0] word;
        logic over_range;
    } aocc_sample_t;

    typedef struct packed {
        logic skip;
        logic half;
        logic [3:0] strobe_phase;
        logic [3:0] word_phase;
        logic [2:0] imp_strobe_a;
        logic [2:0] imp_word_a;
        logic [2:0] imp_strobe_b;
        logic [2:0] imp_word_b;
    } aocc_drive_t;
endpackage

// *** design/aocc_top.sv ***
// converter output control: serial registers, clock divider, formatting, test pattern, pipeline
`timescale 1ns/1ps
module aocc_top #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // serial port, sampled on mclk
    input wire logic serial_port_off,
    input wire logic ser_cs_n,
    input wire logic ser_sclk,
    input wire logic ser_sdio_in,
    output logic ser_sdio_out,
    output logic ser_sdio_oe,
    // parallel strap inputs
    input wire logic [1:0] div_pin,
    input wire logic div_align,
    input wire logic single_bus_interleave,
    // converter core samples
    input wire aocc_pkg::aocc_sample_t core_a,
    input wire aocc_pkg::aocc_sample_t core_b,
    // outputs
    output aocc_pkg::aocc_sample_t out_a,
    output aocc_pkg::aocc_sample_t out_b,
    output logic output_strobe,
    output logic sample_tick,
    output aocc_pkg::aocc_drive_t drive,
    output logic [7:0] bias_cfg
);
    import aocc_pkg::*;

    // ********************************
    // serial register port
    // ********************************
    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_SHIFT = 3'b010,
        SP_DONE = 3'b100
    } aocc_sp_t;

    aocc_sp_t sp_reg, sp_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [15:0] sh_reg, sh_next;
    logic [7:0] rd_reg, rd_next;
    logic sclk_d_reg, sclk_d_next;
    logic oe_reg, oe_next;
    logic [7:0] timing_reg, timing_next;
    logic [7:0] imp_a_reg, imp_a_next;
    logic [7:0] imp_b_reg, imp_b_next;
    logic [7:0] divfmt_reg, divfmt_next;
    logic [7:0] bias_reg, bias_next;
    logic wr_fire;
    logic [6:0] wr_addr;
    logic [7:0] rd_val;

    wire sclk_rise = ser_sclk && !sclk_d_reg;
    wire sclk_fall = !ser_sclk && sclk_d_reg;

    always_comb
    begin
        case ({sh_reg[5:0], ser_sdio_in})
            ADDR_TIMING: rd_val = timing_reg;
            ADDR_IMP_A: rd_val = imp_a_reg;
            ADDR_IMP_B: rd_val = imp_b_reg;
            ADDR_DIVFMT: rd_val = divfmt_reg;
            ADDR_BIAS: rd_val = bias_reg;
            ADDR_SRST: rd_val = SRST_STATUS;
            default: rd_val = RST_ZERO;
        endcase
    end

    always_comb
    begin
        sp_next = sp_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        rd_next = rd_reg;
        oe_next = oe_reg;
        sclk_d_next = ser_sclk;
        wr_fire = 1'b0;
        wr_addr = sh_reg[14:8];
        case (sp_reg)
            SP_IDLE:
            begin
                cnt_next = 5'h00;
                oe_next = 1'b0;
                if (!ser_cs_n && !serial_port_off)
                    sp_next = SP_SHIFT;
            end
            SP_SHIFT:
            begin
                if (sclk_rise)
                begin
                    sh_next = {sh_reg[14:0], ser_sdio_in};
                    cnt_next = cnt_reg + 5'h01;
                    if (cnt_reg == 5'h07 && sh_reg[6])
                        rd_next = rd_val;
                    if (cnt_reg == 5'(SERIAL_BITS - 1))
                        sp_next = SP_DONE;
                end
                // read data leaves on falling edges after address
                if (sclk_fall && cnt_reg >= 5'h08)
                begin
                    if (oe_reg)
                        rd_next = {rd_reg[6:0], 1'b0};
                    oe_next = oe_reg || (cnt_reg == 5'h08 && sh_reg[7]);
                end
                if (ser_cs_n)
                    sp_next = SP_IDLE;
            end
            SP_DONE:
            begin
                wr_fire = !sh_reg[15];
                sp_next = SP_IDLE;
            end
            default: sp_next = SP_IDLE;
        endcase
    end

    wire soft_clear_cmd = wr_fire && wr_addr == ADDR_SRST && sh_reg[7:0] == SRST_KEY;

    always_comb
    begin
        timing_next = timing_reg;
        imp_a_next = imp_a_reg;
        imp_b_next = imp_b_reg;
        divfmt_next = divfmt_reg;
        bias_next = bias_reg;
        if (soft_clear_cmd)
        begin
            timing_next = RST_TIMING;
            imp_a_next = RST_ZERO;
            imp_b_next = RST_ZERO;
            divfmt_next = RST_ZERO;
            bias_next = RST_ZERO;
        end
        else if (wr_fire)
        begin
            // reserved slot and unmapped addresses drop the write
            case (wr_addr)
                ADDR_TIMING: timing_next = sh_reg[7:0];
                ADDR_IMP_A: imp_a_next = sh_reg[7:0];
                ADDR_IMP_B: imp_b_next = sh_reg[7:0];
                ADDR_DIVFMT: divfmt_next = sh_reg[7:0];
                ADDR_BIAS: bias_next = sh_reg[7:0];
                default: bias_next = bias_reg;
            endcase
        end
    end

    // ********************************
    // clock divider and alignment
    // ********************************
    logic [1:0] div_reg, div_next;
    logic align_prev_reg, align_prev_next;
    logic [1:0] align_cnt_reg, align_cnt_next;
    logic [1:0] ratio;
    logic [1:0] div_mask;

    always_comb
    begin
        ratio = serial_port_off ? div_pin : divfmt_reg[1:0];
        case (ratio)
            DIV_BY2: div_mask = 2'h1;
            DIV_BY4: div_mask = 2'h3;
            default: div_mask = 2'h0;
        endcase
    end

    always_comb
    begin
        align_prev_next = div_align;
        align_cnt_next = align_cnt_reg;
        div_next = (div_reg + 2'h1) & div_mask;
        if (div_align && !align_prev_reg)
        begin
            align_cnt_next = 2'(SYNC_EDGE - 1);
        end
        else if (align_cnt_reg != 2'h0)
        begin
            align_cnt_next = align_cnt_reg - 2'h1;
            if (align_cnt_reg == 2'h1)
            begin
                if (divfmt_reg[BIT_ALIGN_EDGE])
                begin
                    div_next = 2'h0;
                end
                else
                begin
                    div_next = div_reg;
                end
            end
        end
    end

    wire tick = div_reg == div_mask;
    assign sample_tick = tick;

    // ********************************
    // formatting, test pattern, latency
    // ********************************
    logic [WIDTH-1:0] ramp_reg, ramp_next;
    logic alt_reg, alt_next;
    aocc_sample_t pipe_a_reg [LATENCY], pipe_a_next [LATENCY];
    aocc_sample_t pipe_b_reg [LATENCY], pipe_b_next [LATENCY];
    aocc_sample_t src_a, src_b, fmt_a, fmt_b;
    logic strobe_reg, strobe_next;

    function automatic aocc_sample_t encode(input aocc_sample_t s, input logic [1:0] f);
        aocc_sample_t r;
        r = s;
        // offset binary in, chosen format out
        if (f == FMT_OFFSET)
            r.word = s.word;
        else if (f == FMT_GRAY)
            r.word = s.word ^ (s.word >> 1);
        else
            r.word = {~s.word[7], s.word[6:0]};
        return r;
    endfunction

    always_comb
    begin
        ramp_next = ramp_reg;
        alt_next = alt_reg;
        if (tick)
        begin
            ramp_next = ramp_reg + 8'h01;
            alt_next = !alt_reg;
        end
        src_a = core_a;
        src_b = core_b;
        if (divfmt_reg[BIT_PAT_EN])
        begin
            if (divfmt_reg[BIT_PAT_SEL])
            begin
                src_a.word = alt_reg ? PAT_EVEN : PAT_ODD;
                src_a.over_range = !alt_reg;
            end
            else
            begin
                src_a.word = ramp_reg;
                src_a.over_range = 1'b0;
            end
            src_b = src_a;
        end
        fmt_a = (divfmt_reg[BIT_PAT_EN] && divfmt_reg[BIT_PAT_SEL]) ? src_a : encode(src_a, divfmt_reg[5:4]);
        fmt_b = (divfmt_reg[BIT_PAT_EN] && divfmt_reg[BIT_PAT_SEL]) ? src_b : encode(src_b, divfmt_reg[5:4]);
        pipe_a_next = pipe_a_reg;
        pipe_b_next = pipe_b_reg;
        strobe_next = tick;
        if (tick)
        begin
            pipe_a_next[0] = fmt_a;
            pipe_b_next[0] = fmt_b;
            for (int i = 1; i < LATENCY; i++)
            begin
                pipe_a_next[i] = pipe_a_reg[i-1];
                pipe_b_next[i] = pipe_b_reg[i-1];
            end
        end
    end

    assign out_a = pipe_a_reg[LATENCY-1];
    assign out_b = pipe_b_reg[LATENCY-1];
    assign output_strobe = strobe_reg;

    // ********************************
    // analog-side settings
    // ********************************
    // signed trims in sixteenths; fine delay lines sit in analog outputs
    function automatic logic [3:0] trim(input logic [2:0] c);
        if (c[2])
            return (c[1:0] == 2'h0) ? 4'h0 : 4'h0 - {2'h0, c[1:0]};
        return {2'h0, c[1:0]};
    endfunction

    always_comb
    begin
        drive.skip = timing_reg[BIT_SKIP];
        // half delay gated in interleave mode
        drive.half = timing_reg[BIT_HALF] && !single_bus_interleave;
        drive.strobe_phase = trim(timing_reg[5:3]) - STROBE_LEAD;
        drive.word_phase = trim(timing_reg[2:0]);
        drive.imp_strobe_a = imp_a_reg[5:3];
        drive.imp_word_a = imp_a_reg[2:0];
        drive.imp_strobe_b = imp_b_reg[5:3];
        drive.imp_word_b = imp_b_reg[2:0];
    end
    assign bias_cfg = bias_reg;
    assign ser_sdio_out = rd_reg[7];
    assign ser_sdio_oe = oe_reg;

    // ********************************
    // state registers
    // ********************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sp_reg <= SP_IDLE;
            cnt_reg <= 5'h00;
            sh_reg <= 16'h0000;
            rd_reg <= RST_ZERO;
            sclk_d_reg <= 1'b0;
            oe_reg <= 1'b0;
            timing_reg <= RST_TIMING;
            imp_a_reg <= RST_ZERO;
            imp_b_reg <= RST_ZERO;
            divfmt_reg <= RST_ZERO;
            bias_reg <= RST_ZERO;
            div_reg <= 2'h0;
            align_prev_reg <= 1'b0;
            align_cnt_reg <= 2'h0;
            ramp_reg <= 8'h00;
            alt_reg <= 1'b0;
            strobe_reg <= 1'b0;
            for (int i = 0; i < LATENCY; i++)
            begin
                pipe_a_reg[i] <= '0;
                pipe_b_reg[i] <= '0;
            end
        end
        else if (clk_en)
        begin
            sp_reg <= sp_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            rd_reg <= rd_next;
            sclk_d_reg <= sclk_d_next;
            oe_reg <= oe_next;
            timing_reg <= timing_next;
            imp_a_reg <= imp_a_next;
            imp_b_reg <= imp_b_next;
            divfmt_reg <= divfmt_next;
            bias_reg <= bias_next;
            div_reg <= div_next;
            align_prev_reg <= align_prev_next;
            align_cnt_reg <= align_cnt_next;
            ramp_reg <= ramp_next;
            alt_reg <= alt_next;
            strobe_reg <= strobe_next;
            pipe_a_reg <= pipe_a_next;
            pipe_b_reg <= pipe_b_next;
        end
    end
endmodule

// *** bench/aocc_top_props.sv ***
// checker: port-level properties of the converter output control
`timescale 1ns/1ps
module aocc_top_props (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // serial and strap pins
    input wire logic serial_port_off,
    input wire logic ser_cs_n,
    input wire logic ser_sdio_oe,
    input wire logic [1:0] div_pin,
    input wire logic single_bus_interleave,
    // output side
    input wire aocc_pkg::aocc_sample_t out_a,
    input wire aocc_pkg::aocc_sample_t out_b,
    input wire logic output_strobe,
    input wire logic sample_tick,
    input wire aocc_pkg::aocc_drive_t drive,
    input wire logic [7:0] bias_cfg
);
    import aocc_pkg::*;
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    chk_strobe_after_tick: assert property ((sample_tick && !reset) |=> output_strobe)
        else $error("strobe missing after tick");
    chk_out_hold: assert property (!sample_tick |=> $stable(out_a) && $stable(out_b))
        else $error("output moved without tick");
    chk_half_off: assert property (single_bus_interleave |-> !drive.half)
        else $error("half delay kept in interleave");
    chk_oe_idle: assert property (ser_cs_n [*3] |-> !ser_sdio_oe)
        else $error("drive outside frame");
    chk_oe_port_off: assert property (serial_port_off [*3] |-> !ser_sdio_oe)
        else $error("drive while port off");
    chk_oe_in_frame: assert property ($rose(ser_sdio_oe) |-> !ser_cs_n)
        else $error("drive began without select");
    // exit of pin mode may cut the second period short
    chk_pin_div_two: assert property ((serial_port_off && div_pin == DIV_BY2 && sample_tick)
        ##1 serial_port_off |-> !sample_tick ##1 (sample_tick || !serial_port_off))
        else $error("pin divide by two broken");
    chk_reset_defaults: assert property ($fell(reset) |-> !drive.skip && bias_cfg == RST_ZERO
        && drive.half == !single_bus_interleave && drive.imp_word_a == 3'h0)
        else $error("defaults missing after reset");

    cov_read: cover property ($rose(ser_sdio_oe));
    cov_flag: cover property (output_strobe && out_a.over_range);
    cov_pin_div: cover property (serial_port_off && sample_tick);
endmodule

bind aocc_top aocc_top_props aocc_top_props_inst (.mclk(mclk), .reset(reset), .serial_port_off(serial_port_off),
    .ser_cs_n(ser_cs_n), .ser_sdio_oe(ser_sdio_oe), .div_pin(div_pin),
    .single_bus_interleave(single_bus_interleave), .out_a(out_a), .out_b(out_b), .output_strobe(output_strobe),
    .sample_tick(sample_tick), .drive(drive), .bias_cfg(bias_cfg));

// *** bench/aocc_capture_model.sv ***
// capture model: far-side logic latching both buses on the strobe
`timescale 1ns/1ps
module aocc_capture_model (
    // clock
    input wire logic mclk,
    // parallel buses
    input wire logic output_strobe,
    input wire aocc_pkg::aocc_sample_t out_a,
    input wire aocc_pkg::aocc_sample_t out_b,
    // captured words
    output aocc_pkg::aocc_sample_t last_a,
    output aocc_pkg::aocc_sample_t last_b,
    output int cap_count
);
    import aocc_pkg::*;
    always @(posedge mclk)
    begin
        if (output_strobe)
        begin
            last_a <= out_a;
            last_b <= out_b;
            cap_count <= cap_count + 1;
        end
    end
endmodule

// *** bench/aocc_top_tb.sv ***
// testbench: serial registers, formats, patterns, divider and alignment
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module aocc_top_tb;
    import aocc_pkg::*;
    typedef struct packed {logic [6:0] a; logic [7:0] rst; logic [7:0] w;} aocc_row_t;
    // ****************
    // tables and signals
    // ****************
    // bypass only with equal trims
    aocc_row_t rows[5] = '{'{ADDR_TIMING, RST_TIMING, 8'h92}, '{ADDR_IMP_A, RST_ZERO, 8'h2B},
        '{ADDR_IMP_B, RST_ZERO, 8'h1C}, '{ADDR_DIVFMT, RST_ZERO, 8'h10}, '{ADDR_BIAS, RST_ZERO, 8'hA5}};
    logic [7:0] ea[4] = '{8'hB3, 8'h33, 8'h2A, 8'hB3};
    logic [7:0] eb[4] = '{8'h44, 8'hC4, 8'hA6, 8'h44};
    logic [7:0] dv[4] = '{8'h10, 8'h11, 8'h12, 8'h13};
    int et[4] = '{40, 20, 10, 40};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic off = 1'b0;
    logic cs_n = 1'b1;
    logic sclk = 1'b0;
    logic sdi = 1'b0;
    logic align = 1'b0;
    logic sbi = 1'b0;
    logic [1:0] dpin = DIV_BY2;
    logic sdo, oe, stb, tick;
    logic [7:0] bias, q;
    aocc_sample_t ca = '{8'h33, 1'b0};
    aocc_sample_t cb = '{8'hC4, 1'b1};
    aocc_sample_t oa, ob, la, lb, a1;
    aocc_drive_t drv;
    int err_total = 0;
    int cmp_count = 0;
    int caps, n, k, d[2];
    int cyc = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    aocc_top #(.WIDTH(8)) aocc_top_inst (.mclk(clk), .reset(rst), .clk_en(1'b1), .serial_port_off(off),
        .ser_cs_n(cs_n), .ser_sclk(sclk), .ser_sdio_in(sdi), .ser_sdio_out(sdo), .ser_sdio_oe(oe),
        .div_pin(dpin), .div_align(align), .single_bus_interleave(sbi), .core_a(ca), .core_b(cb),
        .out_a(oa), .out_b(ob), .output_strobe(stb), .sample_tick(tick), .drive(drv), .bias_cfg(bias));
    aocc_capture_model aocc_capture_model_inst (.mclk(clk), .output_strobe(stb), .out_a(oa), .out_b(ob),
        .last_a(la), .last_b(lb), .cap_count(caps));

    task automatic results();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one bit per sclk, msb first; line inverted once released
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] w, output logic [7:0] r);
        logic [15:0] f;
        f = {rw, a, w};
        r = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            repeat (3) @(posedge clk);
            sclk <= 1'b0;
            sdi <= (rw && i < 8) ? ~sdi : f[i];
            repeat (3) @(posedge clk);
            sclk <= 1'b1;
            r[i % 8] = sdo;
        end
        repeat (3) @(posedge clk);
        sclk <= 1'b0;
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] w);
        xfer(1'b0, a, w, q);
    endtask

    task automatic rd(input logic [6:0] a);
        xfer(1'b1, a, 8'h00, q);
    endtask

    // bounded wait for a tick or a fresh capture
    task automatic wait_ev(input bit cap);
        n = 0;
        k = caps;
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((cap ? caps == k : tick !== 1'b1) && n < 60);
        if (cap ? caps == k : tick !== 1'b1)
        begin
            err_total++;
            results();
        end
    endtask

    task automatic count(output int t, output int c);
        t = 0;
        @(negedge clk);
        c = caps;
        repeat (40)
        begin
            @(negedge clk);
            t += tick;
        end
        c = caps - c;
    endtask

    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            rd(rows[i].a);
            `CHK(q, rows[i].rst)
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            `CHK(q, rows[i].w)
        end
        `CHK(drv.skip, 1'b1)
        `CHK({drv.imp_strobe_a, drv.imp_word_a}, 6'h2B)
        `CHK({drv.imp_strobe_b, drv.imp_word_b}, 6'h1C)
        `CHK(bias, 8'hA5)
        `CHK(drv.word_phase - drv.strobe_phase, STROBE_LEAD)
        wr(ADDR_TIMING, 8'h3B);
        `CHK(drv.word_phase - drv.strobe_phase, 4'h8)
        `CHK(drv.word_phase, 4'h3)
        `CHK(drv.strobe_phase, 4'hB)
        wr(ADDR_SRST, 8'h11);
        rd(ADDR_TIMING);
        `CHK(q, 8'h3B)
        wr(ADDR_SRST, SRST_KEY);
        rd(ADDR_TIMING);
        `CHK(q, RST_TIMING)
        rd(ADDR_IMP_A);
        `CHK(q, RST_ZERO)
        rd(ADDR_SRST);
        `CHK(q, SRST_STATUS)
        `CHK(drv.half, 1'b1)
        sbi <= 1'b1;
        @(negedge clk);
        `CHK(drv.half, 1'b0)
        @(posedge clk);
        sbi <= 1'b0;
        for (int f = 0; f < 4; f++)
        begin
            wr(ADDR_DIVFMT, {2'b00, 2'(f), 4'h0});
            repeat (30) @(posedge clk);
            `CHK(oa.word, ea[f])
            `CHK(ob, {eb[f], 1'b1})
        end
        wr(ADDR_DIVFMT, 8'h50);
        repeat (20) @(posedge clk);
        wait_ev(1'b1);
        a1 = la;
        wait_ev(1'b1);
        `CHK(la.word, a1.word + 8'h01)
        wr(ADDR_DIVFMT, 8'hD0);
        repeat (20) @(posedge clk);
        wait_ev(1'b1);
        a1 = la;
        wait_ev(1'b1);
        `CHK(la.word, ~a1.word)
        `CHK(a1.over_range, a1.word == PAT_ODD)
        `CHK(lb, la)
        wr(ADDR_DIVFMT, 8'h10);
        repeat (30) @(posedge clk);
        `CHK(oa.word, 8'h33)
        ca <= '{8'h5C, 1'b0};
        repeat (8) @(posedge clk);
        @(negedge clk);
        `CHK(oa.word, 8'h33)
        repeat (20) @(posedge clk);
        `CHK(oa.word, 8'h5C)
        foreach (dv[i])
        begin
            wr(ADDR_DIVFMT, dv[i]);
            count(n, k);
            `CHK(n, et[i])
            `CHK(k, n)
        end
        @(posedge clk);
        off <= 1'b1;
        wr(ADDR_BIAS, 8'hFF);
        count(n, k);
        `CHK(n, 20)
        @(posedge clk);
        off <= 1'b0;
        rd(ADDR_BIAS);
        `CHK(q, RST_ZERO)
        wr(ADDR_DIVFMT, 8'h11);
        wait_ev(1'b0);
        d[0] = cyc % 2;
        @(posedge clk);
        align <= 1'b1;
        repeat (8) @(posedge clk);
        align <= 1'b0;
        wait_ev(1'b0);
        d[1] = cyc % 2;
        `CHK(d[1] != d[0], 1'b1)
        wr(ADDR_DIVFMT, 8'h16);
        for (int i = 0; i < 2; i++)
        begin
            repeat (i + 3) @(posedge clk);
            align <= 1'b1;
            repeat (4) @(posedge clk);
            wait_ev(1'b0);
            d[i] = n;
            @(posedge clk);
            align <= 1'b0;
        end
        `CHK(d[1], d[0])
        `CHK(d[0], 3)
        // mid-run reset restores defaults
        wr(ADDR_BIAS, 8'h5A);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK(bias, RST_ZERO)
        rd(ADDR_DIVFMT);
        `CHK(q, RST_ZERO)
        results();
    end
endmodule
